// file: design/pel_error_log.sv
// pci error classification, first/next logging, escalation and apb register file
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

module pel_error_log
  import pel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pci_rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic err_target_abort,
  input wire logic err_master_abort,
  input wire logic err_data_parity,
  input wire logic err_addr_parity,
  input wire logic pci_device_select_pin_n,
  input wire logic err_origin_pci,
  input wire logic [31:0] ctx_addr,
  input wire logic [31:0] ctx_data,
  input wire logic [3:0] ctx_be,
  input wire logic [31:0] ctx_hdr,
  input wire logic [31:0] live_addr,
  input wire logic [31:0] live_data,
  input wire logic [3:0] live_be,
  input wire logic [31:0] live_hdr,
  input wire logic pcie_unc_first,
  input wire logic pcie_unc_next,
  input wire logic [7:0] sram_err_unit,
  input wire logic sram_data_err,
  input wire logic sram_addr_err,
  input wire logic sram_dest_internal,
  output logic data_poison,
  output logic txn_drop,
  output logic err_completion,
  output logic msg_valid,
  output logic [1:0] msg_type,
  input wire logic msg_ready,
  output logic pci_data_parity_error_pin_o,
  output logic pci_data_parity_error_pin_oe_n,
  output logic pci_system_error_pin_o,
  output logic pci_system_error_pin_oe_n
);

  // ==========================================================
  // helpers

  // write-one-to-clear mask for one register offset
  function automatic logic [31:0] pel_clr(input logic wr, input logic [7:0] a,
                                          input logic [7:0] off, input logic [31:0] d);
    pel_clr = (wr && (a == off)) ? d : 32'h0000_0000;
  endfunction

  // true when the offset is a mapped register
  function automatic logic pel_mapped(input logic [7:0] a);
    pel_mapped = (a == PEL_OFF_FIRST) || (a == PEL_OFF_NEXT) ||
                 (a == PEL_OFF_LOG_ADDR) || (a == PEL_OFF_LOG_DATA) ||
                 (a == PEL_OFF_LOG_INFO) || (a == PEL_OFF_LOG_HDR) ||
                 (a == PEL_OFF_GLOBAL) || (a == PEL_OFF_SRAM_CAP) ||
                 (a == PEL_OFF_CTRL);
  endfunction

  // true when a four-bit status value holds either fatal kind
  function automatic logic pel_is_fatal(input logic [3:0] k);
    pel_is_fatal = k[PEL_BIT_DPERR] || k[PEL_BIT_APERR];
  endfunction

  // log kind code of a one-hot event; each kind maps to its own bit index
  function automatic logic [1:0] pel_kind(input logic [3:0] b);
    if (b[PEL_BIT_APERR]) begin
      pel_kind = 2'(PEL_BIT_APERR);
    end else if (b[PEL_BIT_DPERR]) begin
      pel_kind = 2'(PEL_BIT_DPERR);
    end else if (b[PEL_BIT_MABORT]) begin
      pel_kind = 2'(PEL_BIT_MABORT);
    end else begin
      pel_kind = 2'(PEL_BIT_TABORT);
    end
  endfunction

  // an sram fault that kills the transaction: a bad address, or bad data
  // headed to an internal endpoint that cannot take poisoned data
  function automatic logic pel_sram_kill(input logic d, input logic a, input logic i);
    pel_sram_kill = (d && i) || a;
  endfunction

  // ==========================================================
  // state
  pel_state_t s_q;
  pel_state_t s_d;

  logic wr_acc;
  logic rd_setup;
  logic claimed;
  logic [3:0] ev;
  logic [3:0] ev_bit;
  logic ev_fatal;
  logic ev_any;
  logic to_first;
  logic first_fatal;
  logic [31:0] clr_first;
  logic [31:0] clr_next;
  logic [31:0] clr_glob;
  logic [31:0] clr_sram;
  logic sram_any;

  // ==========================================================
  // event qualification and classification
  always_comb begin
    // only cycles this bridge claims and that started on pci get logged here
    claimed = !pci_device_select_pin_n && err_origin_pci;
    ev = 4'h0;
    ev[PEL_BIT_TABORT] = err_target_abort && claimed;
    ev[PEL_BIT_MABORT] = err_master_abort && claimed;
    ev[PEL_BIT_DPERR] = err_data_parity && claimed;
    ev[PEL_BIT_APERR] = err_addr_parity && claimed;
    // one event per cycle; fatal kinds win so the log keeps the worst one
    ev_bit = 4'h0;
    if (ev[PEL_BIT_APERR]) begin
      ev_bit[PEL_BIT_APERR] = 1'b1;
    end else if (ev[PEL_BIT_DPERR]) begin
      ev_bit[PEL_BIT_DPERR] = 1'b1;
    end else if (ev[PEL_BIT_TABORT]) begin
      ev_bit[PEL_BIT_TABORT] = 1'b1;
    end else if (ev[PEL_BIT_MABORT]) begin
      ev_bit[PEL_BIT_MABORT] = 1'b1;
    end
    ev_fatal = pel_is_fatal(ev_bit);
    ev_any = |ev_bit;
    first_fatal = pel_is_fatal(s_q.first);
    // a fatal error takes the first slot unless a fatal is already there;
    // a non-fatal only when the first register is entirely clear
    if (ev_fatal) begin
      to_first = !first_fatal;
    end else begin
      to_first = (s_q.first == 4'h0);
    end
    // any sram report, whatever the unit or kind, feeds the global sram bits
    sram_any = (|sram_err_unit) || sram_data_err || sram_addr_err;
  end

  // ==========================================================
  // apb decode: zero wait states, read data latched in the setup cycle
  // an event landing in the access cycle shows only on the next read
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pready = psel && penable;
  assign prdata = s_q.rdata;
  assign pslverr = s_q.slverr && psel && penable;

  // write-one-to-clear masks for each sticky register
  // log registers have no read side effects; only status and capture clear
  always_comb begin
    clr_first = pel_clr(wr_acc, paddr, PEL_OFF_FIRST, pwdata);
    clr_next = pel_clr(wr_acc, paddr, PEL_OFF_NEXT, pwdata);
    clr_glob = pel_clr(wr_acc, paddr, PEL_OFF_GLOBAL, pwdata);
    clr_sram = pel_clr(wr_acc, paddr, PEL_OFF_SRAM_CAP, pwdata);
  end

  // ==========================================================
  // next-state logic
  always_comb begin
    s_d = s_q;

    // status clears first, so a set arriving in the same cycle wins
    s_d.first = s_q.first & ~clr_first[3:0];
    s_d.next = s_q.next & ~clr_next[3:0];
    s_d.glob = s_q.glob & ~clr_glob[5:0];
    s_d.sram_cap = s_q.sram_cap & ~clr_sram[7:0];

    if (ev_any && to_first) begin
      // a fatal first error replaces only the fatal pair, leaving any
      // non-fatal bit visible so software can see the override happened
      if (ev_fatal) begin
        s_d.first[PEL_BIT_DPERR] = ev_bit[PEL_BIT_DPERR];
        s_d.first[PEL_BIT_APERR] = ev_bit[PEL_BIT_APERR];
      end else begin
        s_d.first[PEL_BIT_TABORT] = ev_bit[PEL_BIT_TABORT];
        s_d.first[PEL_BIT_MABORT] = ev_bit[PEL_BIT_MABORT];
      end
      s_d.glob[PEL_GBIT_PCI_FIRST] = 1'b1;
      // the single log captures whichever error took the first slot
      s_d.log_kind = pel_kind(ev_bit);
      if (ev_bit[PEL_BIT_APERR]) begin
        // the address itself is suspect, so only pin values help decode it
        s_d.log_addr = live_addr;
        s_d.log_data = live_data;
        s_d.log_be = live_be;
        s_d.log_hdr = live_hdr;
      end else if (ev_bit[PEL_BIT_DPERR]) begin
        s_d.log_addr = ctx_addr;
        s_d.log_data = live_data;
        s_d.log_be = live_be;
        s_d.log_hdr = live_hdr;
      end else begin
        // ctx_addr carries the original request address for split cycles
        s_d.log_addr = ctx_addr;
        s_d.log_data = ctx_data;
        s_d.log_be = ctx_be;
        s_d.log_hdr = ctx_hdr;
      end
    end else if (ev_any) begin
      // no transaction details for later errors, status bit only
      s_d.next = s_d.next | ev_bit;
      s_d.glob[PEL_GBIT_PCI_NEXT] = 1'b1;
    end

    // pcie side reports only uncorrectable first and next events here
    if (pcie_unc_first) begin
      s_d.glob[PEL_GBIT_PCIE_FIRST] = 1'b1;
    end
    if (pcie_unc_next) begin
      s_d.glob[PEL_GBIT_PCIE_NEXT] = 1'b1;
    end

    // all sram errors fold into the global sram first and next bits; units kept apart in capture
    s_d.sram_cap = s_d.sram_cap | sram_err_unit;
    if (sram_any) begin
      if (!s_q.glob[PEL_GBIT_SRAM_FIRST]) begin
        s_d.glob[PEL_GBIT_SRAM_FIRST] = 1'b1;
      end else begin
        s_d.glob[PEL_GBIT_SRAM_NEXT] = 1'b1;
      end
    end

    // sram data and address faults on the current transaction
    s_d.poison = sram_data_err && !sram_dest_internal;
    s_d.drop = pel_sram_kill(sram_data_err, sram_addr_err, sram_dest_internal);
    s_d.cpl = pel_sram_kill(sram_data_err, sram_addr_err, sram_dest_internal);

    // upstream messages: pending until taken, a new event wins over the take
    // fatal drains before uncorrectable so the worst news goes upstream first
    if (msg_ready && msg_valid) begin
      if (s_q.pend_fatal) begin
        s_d.pend_fatal = 1'b0;
      end else begin
        s_d.pend_unc = 1'b0;
      end
    end
    if (s_q.ctrl[PEL_CBIT_MSG_EN]) begin
      if (ev_any && ev_fatal) begin
        s_d.pend_fatal = 1'b1;
      end
      if ((ev_any && !ev_fatal) || sram_data_err || sram_addr_err) begin
        s_d.pend_unc = 1'b1;
      end
    end

    // pin pulses: one cycle of low drive per qualifying error
    // no stretching: errors on back-to-back cycles give one longer low drive
    s_d.perr = ev[PEL_BIT_DPERR] && s_q.ctrl[PEL_CBIT_PERR_EN];
    s_d.serr = ev_fatal && s_q.ctrl[PEL_CBIT_SERR_EN];

    // control register write
    if (wr_acc && (paddr == PEL_OFF_CTRL)) begin
      s_d.ctrl = pwdata[2:0];
    end

    // read data captured in setup so it stands for the whole access phase
    if (rd_setup) begin
      s_d.slverr = !pel_mapped(paddr);
      case (paddr)
        PEL_OFF_FIRST: s_d.rdata = {28'h0000000, s_q.first};
        PEL_OFF_NEXT: s_d.rdata = {28'h0000000, s_q.next};
        PEL_OFF_LOG_ADDR: s_d.rdata = s_q.log_addr;
        PEL_OFF_LOG_DATA: s_d.rdata = s_q.log_data;
        PEL_OFF_LOG_INFO: s_d.rdata = {22'h0, s_q.log_kind, 4'h0, s_q.log_be};
        PEL_OFF_LOG_HDR: s_d.rdata = s_q.log_hdr;
        PEL_OFF_GLOBAL: s_d.rdata = {26'h0, s_q.glob};
        PEL_OFF_SRAM_CAP: s_d.rdata = {24'h000000, s_q.sram_cap};
        PEL_OFF_CTRL: s_d.rdata = {29'h0, s_q.ctrl};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // secondary reset restores control to its reset value and clears signalling but never the logs
    if (!pci_rst_n) begin
      s_d.ctrl = PEL_CTRL_RESET;
      s_d.pend_fatal = 1'b0;
      s_d.pend_unc = 1'b0;
      s_d.perr = 1'b0;
      s_d.serr = 1'b0;
      s_d.poison = 1'b0;
      s_d.drop = 1'b0;
      s_d.cpl = 1'b0;
    end
  end

  // ==========================================================
  // state register; presetn is the power-good reset, the only one
  // that wipes the logs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ctrl <= PEL_CTRL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  // sram fault indications are registered one-cycle pulses
  assign data_poison = s_q.poison;
  assign txn_drop = s_q.drop;
  assign err_completion = s_q.cpl;
  assign msg_valid = s_q.pend_fatal || s_q.pend_unc;
  // fatal goes first; correctable is never produced by pci bus errors
  assign msg_type = s_q.pend_fatal ? 2'(PEL_MSG_FATAL) : 2'(PEL_MSG_UNC);
  // both pins only ever pull low; the enable is active low
  assign pci_data_parity_error_pin_o = 1'b0;
  assign pci_data_parity_error_pin_oe_n = !s_q.perr;
  assign pci_system_error_pin_o = 1'b0;
  assign pci_system_error_pin_oe_n = !s_q.serr;

endmodule // pel_error_log

// file: shared/pel_pkg.sv
// constants, register map and state types for the pci error classify and log block
package pel_pkg;

  // ==========================================================
  // register byte offsets on apb
  localparam logic [7:0] PEL_OFF_FIRST = 8'h00;
  localparam logic [7:0] PEL_OFF_NEXT = 8'h04;
  localparam logic [7:0] PEL_OFF_LOG_ADDR = 8'h08;
  localparam logic [7:0] PEL_OFF_LOG_DATA = 8'h0C;
  localparam logic [7:0] PEL_OFF_LOG_INFO = 8'h10;
  localparam logic [7:0] PEL_OFF_LOG_HDR = 8'h14;
  localparam logic [7:0] PEL_OFF_GLOBAL = 8'h18;
  localparam logic [7:0] PEL_OFF_SRAM_CAP = 8'h1C;
  localparam logic [7:0] PEL_OFF_CTRL = 8'h20;

  // ==========================================================
  // bit positions in first and next error status
  localparam int PEL_BIT_TABORT = 0;
  localparam int PEL_BIT_MABORT = 1;
  localparam int PEL_BIT_DPERR = 2;
  localparam int PEL_BIT_APERR = 3;

  // bit positions in global error status
  localparam int PEL_GBIT_PCIE_FIRST = 0;
  localparam int PEL_GBIT_PCI_FIRST = 1;
  localparam int PEL_GBIT_SRAM_FIRST = 2;
  localparam int PEL_GBIT_PCIE_NEXT = 3;
  localparam int PEL_GBIT_PCI_NEXT = 4;
  localparam int PEL_GBIT_SRAM_NEXT = 5;

  // control bits
  localparam int PEL_CBIT_SERR_EN = 0;
  localparam int PEL_CBIT_PERR_EN = 1;
  localparam int PEL_CBIT_MSG_EN = 2;
  localparam logic [2:0] PEL_CTRL_RESET = 3'h7;

  // log info field: byte enables in [3:0], error kind in [9:8]
  localparam int PEL_INFO_KIND_LSB = 8;

  // ==========================================================
  // upstream error message codes
  typedef enum logic [1:0] {
    PEL_MSG_COR = 2'b00,
    PEL_MSG_UNC = 2'b01,
    PEL_MSG_FATAL = 2'b10
  } pel_msg_t;

  // ==========================================================
  // whole state of the block
  typedef struct packed {
    logic [3:0] first;
    logic [3:0] next;
    logic [31:0] log_addr;
    logic [31:0] log_data;
    logic [3:0] log_be;
    logic [1:0] log_kind;
    logic [31:0] log_hdr;
    logic [5:0] glob;
    logic [7:0] sram_cap;
    logic [2:0] ctrl;
    logic pend_fatal;
    logic pend_unc;
    logic perr;
    logic serr;
    logic poison;
    logic drop;
    logic cpl;
    logic [31:0] rdata;
    logic slverr;
  } pel_state_t;

endpackage

// file: verification/pel_error_log_properties.sv
// concurrent checks on the ports of the pci error classify and log block
`timescale 1ns/1ps
module pel_error_log_properties
  import pel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pci_rst_n,
  input wire logic err_target_abort,
  input wire logic err_master_abort,
  input wire logic err_data_parity,
  input wire logic err_addr_parity,
  input wire logic pci_device_select_pin_n,
  input wire logic err_origin_pci,
  input wire logic sram_data_err,
  input wire logic sram_addr_err,
  input wire logic sram_dest_internal,
  input wire logic data_poison,
  input wire logic txn_drop,
  input wire logic err_completion,
  input wire logic msg_valid,
  input wire logic [1:0] msg_type,
  input wire logic msg_ready,
  input wire logic pci_data_parity_error_pin_o,
  input wire logic pci_data_parity_error_pin_oe_n,
  input wire logic pci_system_error_pin_o,
  input wire logic pci_system_error_pin_oe_n
);
  // ==========================================================
  // an event only counts when claimed, from the pci side, out of hot reset
  wire claimed = pci_rst_n && !pci_device_select_pin_n && err_origin_pci;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence fatal_s;
    claimed && (err_data_parity || err_addr_parity);
  endsequence
  sequence nonfatal_s;
    claimed && (err_target_abort || err_master_abort) && !err_data_parity && !err_addr_parity;
  endsequence
  parity_pin_pulse_a: assert property (
    claimed && err_data_parity |=> !pci_data_parity_error_pin_oe_n)
    else $error("parity pin not driven");
  fatal_sys_pin_a: assert property (
    fatal_s |=> !pci_system_error_pin_oe_n)
    else $error("system error pin not driven");
  nonfatal_quiet_a: assert property (
    nonfatal_s |=> pci_system_error_pin_oe_n)
    else $error("system error pin on non-fatal");
  unclaimed_quiet_a: assert property (
    (err_data_parity || err_addr_parity) && pci_device_select_pin_n
    |=> pci_system_error_pin_oe_n && pci_data_parity_error_pin_oe_n)
    else $error("unclaimed error reported");
  pin_drives_low_a: assert property (
    !pci_data_parity_error_pin_oe_n |-> !pci_data_parity_error_pin_o)
    else $error("parity pin driven high");
  sys_pin_low_a: assert property (
    !pci_system_error_pin_oe_n |-> !pci_system_error_pin_o)
    else $error("system error pin driven high");
  fatal_msg_a: assert property (
    fatal_s |=> msg_valid && msg_type == PEL_MSG_FATAL)
    else $error("no fatal message");
  nonfatal_msg_a: assert property (
    nonfatal_s ##0 !msg_valid |=> msg_valid && msg_type == PEL_MSG_UNC)
    else $error("no uncorrectable message");
  // a hot reset of the segment drops pending messages on purpose
  msg_hold_a: assert property (
    msg_valid && !msg_ready && pci_rst_n |=> msg_valid)
    else $error("message dropped before taken");
  msg_never_cor_a: assert property (
    msg_valid |-> msg_type != PEL_MSG_COR)
    else $error("correctable message sent");
  poison_fwd_a: assert property (
    pci_rst_n && sram_data_err && !sram_dest_internal && !sram_addr_err
    |=> data_poison && !txn_drop)
    else $error("data not poisoned");
  internal_drop_a: assert property (
    pci_rst_n && sram_data_err && sram_dest_internal |=> txn_drop && !data_poison)
    else $error("internal data not dropped");
  addr_drop_a: assert property (
    pci_rst_n && sram_addr_err |=> txn_drop && err_completion)
    else $error("corrupt address not dropped");
endmodule // pel_error_log_properties

// file: verification/pel_msg_sink.sv
// upstream link partner that takes error messages with a stalling ready
`timescale 1ns/1ps
module pel_msg_sink
  import pel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic msg_valid,
  input wire logic [1:0] msg_type,
  output logic msg_ready,
  output int fatal_cnt,
  output int unc_cnt
);
  // ==========================================================
  // ready every other cycle, so a message must wait and stand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_ready <= 1'b0;
      fatal_cnt <= 0;
      unc_cnt <= 0;
    end else begin
      msg_ready <= !msg_ready;
      if (msg_valid && msg_ready && msg_type == PEL_MSG_FATAL) fatal_cnt <= fatal_cnt + 1;
      if (msg_valid && msg_ready && msg_type == PEL_MSG_UNC) unc_cnt <= unc_cnt + 1;
    end
  end
endmodule // pel_msg_sink

// file: verification/test_pel_error_log.sv
// self-checking bench for the pci error classify and log block
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module test_pel_error_log;
  import pel_pkg::*;
  logic pclk = 0, presetn = 0, pci_rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, sram_err_unit = 0;
  logic [31:0] pwdata = 0, prdata, r, ctx_addr = 0, ctx_data = 0, ctx_hdr = 0;
  logic [31:0] live_addr = 0, live_data = 0, live_hdr = 0;
  logic [3:0] ctx_be = 0, live_be = 0;
  logic pready, pslverr, slv, data_poison, txn_drop, err_completion, msg_valid, msg_ready;
  logic err_target_abort = 0, err_master_abort = 0, err_data_parity = 0, err_addr_parity = 0;
  logic pci_device_select_pin_n = 1, err_origin_pci = 0, pcie_unc_first = 0, pcie_unc_next = 0;
  logic sram_data_err = 0, sram_addr_err = 0, sram_dest_internal = 0;
  logic [1:0] msg_type;
  logic pci_data_parity_error_pin_o, pci_data_parity_error_pin_oe_n;
  logic pci_system_error_pin_o, pci_system_error_pin_oe_n;
  int errors = 0, comparisons = 0, fatal_cnt, unc_cnt;
  pel_error_log dut_u (.pclk, .presetn, .pci_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .err_target_abort, .err_master_abort, .err_data_parity,
    .err_addr_parity, .pci_device_select_pin_n, .err_origin_pci, .ctx_addr, .ctx_data, .ctx_be,
    .ctx_hdr, .live_addr, .live_data, .live_be, .live_hdr, .pcie_unc_first, .pcie_unc_next,
    .sram_err_unit, .sram_data_err, .sram_addr_err, .sram_dest_internal, .data_poison, .txn_drop,
    .err_completion, .msg_valid, .msg_type, .msg_ready, .pci_data_parity_error_pin_o,
    .pci_data_parity_error_pin_oe_n, .pci_system_error_pin_o, .pci_system_error_pin_oe_n);
  pel_msg_sink p_u (.pclk, .presetn, .msg_valid, .msg_type, .msg_ready, .fatal_cnt, .unc_cnt);
  // ==========================================================
  // apb master: request held until pready is seen at a rising edge;
  // only the watchdog ends a wait that never returns
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(r, e)
  endtask
  // one-cycle pci error event; context and live values derived from s
  task automatic ev(input logic [3:0] k, input logic cl, input logic og, input logic [31:0] s);
    @(posedge pclk);
    err_target_abort <= k[PEL_BIT_TABORT];
    err_master_abort <= k[PEL_BIT_MABORT];
    err_data_parity <= k[PEL_BIT_DPERR];
    err_addr_parity <= k[PEL_BIT_APERR];
    pci_device_select_pin_n <= !cl;
    err_origin_pci <= og;
    ctx_addr <= s;
    ctx_data <= ~s;
    ctx_be <= 4'h3;
    ctx_hdr <= s ^ 32'h00FF00FF;
    live_addr <= s ^ 32'h0F0F0F0F;
    live_data <= s + 32'h1;
    live_be <= 4'hC;
    live_hdr <= s ^ 32'hFFFF0000;
    @(posedge pclk);
    {err_target_abort, err_master_abort, err_data_parity, err_addr_parity} <= 4'h0;
    pci_device_select_pin_n <= 1'b1;
  endtask
  // one-cycle sram and pcie side events
  task automatic sr(input logic d, input logic a, input logic i, input logic [7:0] u,
                    input logic [1:0] p);
    @(posedge pclk);
    {sram_data_err, sram_addr_err, sram_dest_internal, sram_err_unit} <= {d, a, i, u};
    {pcie_unc_next, pcie_unc_first} <= p;
    @(posedge pclk);
    {sram_data_err, sram_addr_err, sram_err_unit, pcie_unc_next, pcie_unc_first} <= 12'h000;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // clock and watchdog; the tests need a few hundred cycles at most
  initial forever #10 pclk = ~pclk;
  initial begin
    #200us;
    errors++;
    report_and_stop();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    pci_rst_n <= 1'b1;
    rd(PEL_OFF_FIRST, 32'h0);
    rd(PEL_OFF_CTRL, 32'h7);
    $display("test reset done");
    ev(4'h1, 1, 1, 32'h10000010);
    rd(PEL_OFF_FIRST, 32'h1);
    rd(PEL_OFF_LOG_ADDR, 32'h10000010);
    rd(PEL_OFF_LOG_DATA, ~32'h10000010);
    rd(PEL_OFF_LOG_HDR, 32'h10FF00EF);
    rd(PEL_OFF_LOG_INFO, 32'h00000003);
    ev(4'h2, 1, 1, 32'h20000020);
    rd(PEL_OFF_NEXT, 32'h2);
    rd(PEL_OFF_FIRST, 32'h1);
    rd(PEL_OFF_LOG_ADDR, 32'h10000010);
    ev(4'h4, 1, 1, 32'h30000030);
    rd(PEL_OFF_FIRST, 32'h5);
    rd(PEL_OFF_LOG_ADDR, 32'h30000030);
    rd(PEL_OFF_LOG_DATA, 32'h30000031);
    rd(PEL_OFF_LOG_INFO, 32'h0000020C);
    ev(4'h1, 1, 1, 32'h40000040);
    ev(4'h8, 1, 1, 32'h50000050);
    rd(PEL_OFF_FIRST, 32'h5);
    rd(PEL_OFF_NEXT, 32'hB);
    rd(PEL_OFF_LOG_ADDR, 32'h30000030);
    rd(PEL_OFF_GLOBAL, 32'h12);
    $display("test first next override done");
    apb(1'b1, PEL_OFF_FIRST, 32'h4);
    rd(PEL_OFF_FIRST, 32'h1);
    apb(1'b1, PEL_OFF_FIRST, 32'h1);
    apb(1'b1, PEL_OFF_NEXT, 32'hF);
    apb(1'b1, PEL_OFF_GLOBAL, 32'h3F);
    rd(PEL_OFF_NEXT, 32'h0);
    rd(PEL_OFF_GLOBAL, 32'h0);
    ev(4'h8, 1, 1, 32'h60000060);
    ev(4'h8, 0, 1, 32'h70000070);
    ev(4'h1, 1, 0, 32'h80000080);
    rd(PEL_OFF_FIRST, 32'h8);
    rd(PEL_OFF_NEXT, 32'h0);
    rd(PEL_OFF_LOG_ADDR, 32'h6F0F0F6F);
    rd(PEL_OFF_LOG_HDR, 32'h9FFF0060);
    rd(PEL_OFF_LOG_INFO, 32'h0000030C);
    apb(1'b1, PEL_OFF_CTRL, 32'h0);
    rd(PEL_OFF_CTRL, 32'h0);
    @(posedge pclk);
    pci_rst_n <= 1'b0;
    repeat (2) @(posedge pclk);
    pci_rst_n <= 1'b1;
    rd(PEL_OFF_FIRST, 32'h8);
    rd(PEL_OFF_CTRL, 32'h7);
    rd(PEL_OFF_LOG_DATA, 32'h60000061);
    $display("test clear and live log done");
    apb(1'b1, PEL_OFF_GLOBAL, 32'h3F);
    sr(1, 0, 0, 8'h05, 2'h0);
    rd(PEL_OFF_GLOBAL, 32'h4);
    sr(0, 0, 0, 8'h00, 2'h1);
    sr(0, 0, 0, 8'h00, 2'h2);
    sr(0, 1, 0, 8'h80, 2'h0);
    sr(1, 0, 1, 8'h00, 2'h0);
    rd(PEL_OFF_GLOBAL, 32'h2D);
    rd(PEL_OFF_SRAM_CAP, 32'h85);
    apb(1'b0, 8'h24, 32'h0);
    `CHK(slv, 1'b1)
    `CHK(r, 32'h0)
    `CHK(fatal_cnt != 0, 1'b1)
    `CHK(unc_cnt != 0, 1'b1)
    $display("test sram global messages done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(PEL_OFF_FIRST, 32'h0);
    $display("test power reset done");
    report_and_stop();
  end
endmodule // test_pel_error_log
bind pel_error_log pel_error_log_properties chk_u (.pclk(pclk), .presetn(presetn),
  .pci_rst_n(pci_rst_n), .err_target_abort(err_target_abort),
  .err_master_abort(err_master_abort), .err_data_parity(err_data_parity),
  .err_addr_parity(err_addr_parity), .pci_device_select_pin_n(pci_device_select_pin_n),
  .err_origin_pci(err_origin_pci), .sram_data_err(sram_data_err),
  .sram_addr_err(sram_addr_err), .sram_dest_internal(sram_dest_internal),
  .data_poison(data_poison), .txn_drop(txn_drop), .err_completion(err_completion),
  .msg_valid(msg_valid), .msg_type(msg_type), .msg_ready(msg_ready),
  .pci_data_parity_error_pin_o(pci_data_parity_error_pin_o),
  .pci_data_parity_error_pin_oe_n(pci_data_parity_error_pin_oe_n),
  .pci_system_error_pin_o(pci_system_error_pin_o),
  .pci_system_error_pin_oe_n(pci_system_error_pin_oe_n));
